// ---- hdl/gsst_start_seq.sv ----
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// RQ1: Wait for one external start trigger; later triggers never restart the sequence.
// RQ2: After the start trigger, self-time exposures and readouts like internal triggering.
// RQ3: Trigger-ready output is high whenever a start trigger would be accepted.
// RQ4: Trigger source holds the trigger high at least two sensor clocks.
// RQ5: Overlap off start delay: 0..1 frame short, 1..2 rows long exposure.
// RQ6: Overlap on accepts frame+interframe+1 row to 30 s, 1..2 row delay.
// RQ7: Overlap off: short 1 row..frame+3 rows, long frame+4 rows..30 s; code accepts short only to frame-1 rows.
// RQ8: Overlap on minimum exposure is frame plus interframe plus one row.
// RQ9: Exposure and cycle time are programmed; only start comes from the trigger.
// RQ10: Exposure is a whole count of row periods, rounded to nearest.
// RQ11: One row period is 2624 sensor clocks, scaling with readout rate.
// RQ12: One frame is the region height in rows, 1080 at full size.
// RQ13: Exposure below frame readout time is short, otherwise long.
// RQ14: Controller stops acquisition before moving between short and long classes.
// RQ15: Exposure may change while running, limited to the mode's range.
// RQ16: Ready drops once start is accepted; triggers ignored until acquisition ends.
// RQ17: Exposure and delay are row counts; frame length set from region height.
module gsst_start_seq
  import gsst_pkg::*;
#(
  parameter int unsigned ROW_CLKS = GSST_ROW_CLKS,
  parameter int unsigned EXP_MAX_ROWS = GSST_EXP_MAX_ROWS,
  parameter int unsigned TRIG_MIN = GSST_TRIG_MIN_CLKS
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic acq_start_in,
  input wire logic acq_stop_in,
  input wire logic external_trigger_input_in,
  input wire logic [GSST_DIV_W-1:0] clk_div_in,
  input wire gsst_cfg_t cfg_in,
  input wire logic [GSST_ROW_W+3:0] exp_req_frac_in,
  input wire logic exp_req_load_in,
  output gsst_stat_t stat_out,
  output logic global_clear_out,
  output logic charge_transfer_out,
  output logic [GSST_ROW_W-1:0] exp_rows_out
);
  // ==========================================================================
  // Declarations
  // ==========================================================================
  gsst_state_t state_reg, state_next;
  logic [GSST_ROW_W-1:0] cnt_reg, cnt_next;
  logic [GSST_ROW_W-1:0] cyc_reg, cyc_next;
  logic [GSST_ROW_W-1:0] exp_reg;
  logic [GSST_ROW_W-1:0] exp_pend_reg;
  logic pend_reg;
  logic [GSST_CNT_W-1:0] frame_reg;
  logic [GSST_DIV_W-1:0] pre_reg;
  logic [1:0] hold_reg;
  // Running follows the next state so it rises with the fall of ready,
  // leaving no cycle in which neither is shown
  wire run_next = (state_next != GSST_IDLE) && (state_next != GSST_ARMED); // RQ16
  logic trig_prev_reg;
  logic running_reg;
  logic long_reg;
  logic rej_reg;
  logic row_tick;

  // Sign-free rounding of a 4-bit fractional row request
  function automatic logic [GSST_ROW_W-1:0] round_rows(input logic [GSST_ROW_W+3:0] v);
    logic [GSST_ROW_W+4:0] s;
    s = {1'b0, v} + 29'h0000008;
    return s[GSST_ROW_W+3:4];
  endfunction

  // Short/long decision against the frame readout length
  function automatic logic is_long(input logic [GSST_ROW_W-1:0] e,
                                   input logic [GSST_CNT_W-1:0] f);
    return e >= {12'h000, f};
  endfunction

  // ==========================================================================
  // Range limits in rows
  // ==========================================================================
  wire [GSST_ROW_W-1:0] frame_w = {12'h000, frame_reg};
  wire [GSST_ROW_W-1:0] short_max = frame_w + 24'(GSST_SHORT_EXTRA_ROWS); // RQ7
  wire [GSST_ROW_W-1:0] long_min = frame_w + 24'(GSST_LONG_EXTRA_ROWS); // RQ7
  wire [GSST_ROW_W-1:0] ovl_min = frame_w + {12'h000, cfg_in.interframe_rows}
    + 24'(GSST_OVL_EXTRA_ROWS); // RQ8
  wire [GSST_ROW_W-1:0] exp_max = 24'(EXP_MAX_ROWS);
  wire [GSST_ROW_W-1:0] req_rows = round_rows(exp_req_frac_in); // RQ10
  wire req_long = is_long(req_rows, frame_reg); // RQ13
  wire cur_long = is_long(exp_reg, frame_reg);
  wire req_ok_ovl = (req_rows >= ovl_min) && (req_rows <= exp_max); // RQ6
  wire req_ok_short = (req_rows >= 24'h000001) && (req_rows <= short_max);
  wire req_ok_long = (req_rows >= long_min) && (req_rows <= exp_max);
  wire req_ok_cls = req_long ? req_ok_long : req_ok_short; // RQ7
  wire same_cls = !running_reg || (req_long == cur_long); // RQ14
  wire req_ok = (cfg_in.overlap ? req_ok_ovl : req_ok_cls) && same_cls; // RQ15

  // Trigger width filter: high for the minimum sensor clocks counts as a start
  wire sens_tick = (pre_reg == clk_div_in);
  wire trig_valid = (hold_reg >= 2'(TRIG_MIN)); // RQ4
  wire armed = (state_reg == GSST_ARMED);
  wire start_take = armed && trig_valid && !trig_prev_reg; // RQ1
  // Long exposures and overlap wait a row before clear; short exposures
  // start at once and absorb up to one frame of jitter in the readout.
  wire [GSST_ROW_W-1:0] dly_rows = (cfg_in.overlap || long_reg) ?
    24'(GSST_DLY_LONG_ROWS) : 24'h000000; // RQ5
  wire [GSST_ROW_W-1:0] cyc_min = exp_reg + frame_w + {12'h000, cfg_in.interframe_rows};
  wire [GSST_ROW_W-1:0] cyc_eff = (cfg_in.cycle_rows > cyc_min) ?
    cfg_in.cycle_rows : cyc_min; // RQ9
  wire row_run = running_reg;

  gsst_row_timer #(
    .ROW_CLKS(ROW_CLKS),
    .DIV_MAX(1)
  ) u_row (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .run_in(row_run),
    .clk_div_in(clk_div_in),
    .row_tick_out(row_tick)
  );

  // ==========================================================================
  // Trigger capture
  // ==========================================================================
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pre_reg <= 8'h00;
      hold_reg <= 2'h0;
      trig_prev_reg <= 1'b0;
    end else begin
      pre_reg <= sens_tick ? 8'h00 : pre_reg + 8'h01;
      if (!external_trigger_input_in) begin
        hold_reg <= 2'h0;
      end else if (sens_tick && !trig_valid) begin
        hold_reg <= hold_reg + 2'h1;
      end
      trig_prev_reg <= trig_valid; // one start per held pulse
    end
  end

  // ==========================================================================
  // Configuration and exposure update
  // ==========================================================================
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      frame_reg <= 12'(GSST_FULL_ROWS);
      exp_reg <= 24'h000001;
      exp_pend_reg <= 24'h000001;
      pend_reg <= 1'b0;
      rej_reg <= 1'b0;
      long_reg <= 1'b0;
    end else begin
      if (!running_reg) begin
        frame_reg <= cfg_in.region_rows; // RQ12
      end
      if (exp_req_load_in) begin
        rej_reg <= !req_ok;
        if (req_ok) begin
          exp_pend_reg <= req_rows; // RQ17
          pend_reg <= 1'b1;
        end
      end
      // New value applies after the current exposure completes
      if (pend_reg && state_reg != GSST_EXPOSE && state_reg != GSST_DELAY) begin
        exp_reg <= exp_pend_reg; // RQ15
        long_reg <= is_long(exp_pend_reg, frame_reg);
        pend_reg <= exp_req_load_in && req_ok;
      end
    end
  end

  // ==========================================================================
  // Sequencer next state
  // ==========================================================================
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    cyc_next = cyc_reg;
    case (state_reg)
      GSST_IDLE: begin
        if (acq_start_in) begin
          state_next = GSST_ARMED;
        end
      end
      GSST_ARMED: begin
        if (start_take) begin
          state_next = GSST_DELAY; // RQ1
          cnt_next = dly_rows;
          cyc_next = cyc_eff;
        end
      end
      GSST_DELAY: begin
        if (cnt_reg == 24'h000000) begin
          state_next = GSST_EXPOSE;
          cnt_next = exp_reg;
        end else if (row_tick) begin
          cnt_next = cnt_reg - 24'h000001; // RQ17
        end
      end
      GSST_EXPOSE: begin
        if (row_tick) begin
          if (cnt_reg <= 24'h000001) begin
            state_next = GSST_READ;
            cnt_next = frame_w;
          end else begin
            cnt_next = cnt_reg - 24'h000001;
          end
        end
      end
      GSST_READ: begin
        if (row_tick) begin
          if (cnt_reg <= 24'h000001) begin
            state_next = GSST_WAIT;
          end else begin
            cnt_next = cnt_reg - 24'h000001;
          end
        end
      end
      GSST_WAIT: begin
        // Self-timed next frame, as internal triggering would do
        if (row_tick) begin
          if (cyc_reg <= 24'h000001) begin
            state_next = GSST_EXPOSE; // RQ2
            cnt_next = exp_reg;
            cyc_next = cyc_eff;
          end else begin
            cyc_next = cyc_reg - 24'h000001;
          end
        end
      end
      default: begin
        state_next = GSST_IDLE;
      end
    endcase
    if (state_reg != GSST_IDLE && state_reg != GSST_ARMED && row_tick
        && state_reg != GSST_WAIT && state_next != GSST_WAIT) begin
      cyc_next = (cyc_next > 24'h000000) ? cyc_next - 24'h000001 : cyc_next;
    end
    if (acq_stop_in) begin
      state_next = GSST_IDLE;
    end
  end

  // ==========================================================================
  // Sequencer registers and outputs
  // ==========================================================================
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= GSST_IDLE;
      cnt_reg <= 24'h000000;
      cyc_reg <= 24'h000000;
      running_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      cyc_reg <= cyc_next;
      running_reg <= run_next;
    end
  end

  // Registered status and sensor control strobes
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      stat_out <= '0;
      global_clear_out <= 1'b0;
      charge_transfer_out <= 1'b0;
      exp_rows_out <= 24'h000001;
    end else begin
      stat_out.trig_ready <= (state_next == GSST_ARMED); // RQ3
      stat_out.running <= run_next; // RQ16
      stat_out.exposing <= (state_next == GSST_EXPOSE);
      stat_out.reading <= (state_next == GSST_READ);
      stat_out.long_exp <= long_reg; // RQ13
      stat_out.exp_rejected <= rej_reg;
      global_clear_out <= (state_reg != GSST_EXPOSE) && (state_next == GSST_EXPOSE);
      charge_transfer_out <= (state_reg == GSST_EXPOSE) && (state_next == GSST_READ);
      exp_rows_out <= exp_reg;
    end
  end
endmodule
`default_nettype wire

// ---- inc/gsst_pkg.sv ----
package gsst_pkg;
  // ==========================================================================
  // Timing constants
  // ==========================================================================
  localparam int unsigned GSST_CLK_PERIOD_NS = 8;
  localparam int unsigned GSST_CLK_HZ = 125000000;
  // Sensor clock cycles in one complete row readout
  localparam int unsigned GSST_ROW_CLKS = 2624;
  // Rows read by each sensor half at full size
  localparam int unsigned GSST_FULL_ROWS = 1080;
  // Least held width of the start trigger, in sensor clocks
  localparam int unsigned GSST_TRIG_MIN_CLKS = 2;
  // Longest exposure in seconds and in rows at the fastest row rate
  localparam int unsigned GSST_EXP_MAX_S = 30;
  localparam longint unsigned GSST_EXP_MAX_CLKS = 64'(GSST_EXP_MAX_S) * 64'(GSST_CLK_HZ);
  localparam int unsigned GSST_EXP_MAX_ROWS = 32'(GSST_EXP_MAX_CLKS / 64'(GSST_ROW_CLKS));
  // Margins in rows around the frame length
  localparam int unsigned GSST_SHORT_EXTRA_ROWS = 3;
  localparam int unsigned GSST_LONG_EXTRA_ROWS = 4;
  localparam int unsigned GSST_OVL_EXTRA_ROWS = 1;
  localparam int unsigned GSST_DLY_LONG_ROWS = 1;
  // Field widths
  localparam int unsigned GSST_ROW_W = 24;
  localparam int unsigned GSST_CNT_W = 12;
  localparam int unsigned GSST_DIV_W = 8;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [2:0] {
    GSST_IDLE = 3'b000,
    GSST_ARMED = 3'b001,
    GSST_DELAY = 3'b010,
    GSST_EXPOSE = 3'b011,
    GSST_READ = 3'b100,
    GSST_WAIT = 3'b101
  } gsst_state_t;

  // Configuration sampled by the sequencer
  typedef struct packed {
    logic overlap;
    logic [GSST_ROW_W-1:0] exp_rows;
    logic [GSST_ROW_W-1:0] cycle_rows;
    logic [GSST_CNT_W-1:0] region_rows;
    logic [GSST_CNT_W-1:0] interframe_rows;
  } gsst_cfg_t;

  // Status seen by the controlling party
  typedef struct packed {
    logic trig_ready;
    logic running;
    logic exposing;
    logic reading;
    logic long_exp;
    logic exp_rejected;
  } gsst_stat_t;
endpackage

// ---- hdl/gsst_row_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
// ============================================================================
// Row period divider
// ============================================================================
module gsst_row_timer
  import gsst_pkg::*;
#(
  parameter int unsigned ROW_CLKS = GSST_ROW_CLKS,
  parameter int unsigned DIV_MAX = 1
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic run_in,
  input wire logic [GSST_DIV_W-1:0] clk_div_in,
  output logic row_tick_out
);
  logic [GSST_DIV_W-1:0] pre_reg;
  logic [15:0] cnt_reg;
  wire sens_tick = (pre_reg == clk_div_in);
  wire row_end = sens_tick && (cnt_reg == 16'(ROW_CLKS - 1));

  // Sensor clock enable from the system clock; readout rate scales the row
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pre_reg <= 8'h00;
    end else if (!run_in || sens_tick) begin
      pre_reg <= 8'h00;
    end else begin
      pre_reg <= pre_reg + 8'h01;
    end
  end

  // Row counter restarts with run so the first row is always whole
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_reg <= 16'h0000;
      row_tick_out <= 1'b0;
    end else begin
      row_tick_out <= run_in && row_end; // RQ11
      if (!run_in || row_end) begin
        cnt_reg <= 16'h0000;
      end else if (sens_tick) begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// ---- sim/gsst_start_seq_props.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Port checker for the start sequencer
module gsst_start_seq_props
  import gsst_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic acq_stop_in,
  input wire gsst_cfg_t cfg_in,
  input wire gsst_stat_t stat_out,
  input wire logic global_clear_out,
  input wire logic charge_transfer_out,
  input wire logic [GSST_ROW_W-1:0] exp_rows_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // Class bounds assume the region height is held steady while running
  chk_ready_idle: assert property (stat_out.trig_ready |-> !stat_out.running)
    else $error("ready while running");
  chk_ready_drop: assert property ($fell(stat_out.trig_ready) && !$past(acq_stop_in)
    |-> stat_out.running) else $error("ready fell without start");
  chk_no_restart: assert property (stat_out.running && !acq_stop_in
    |=> !stat_out.trig_ready) else $error("ready came back while running");
  chk_clear_strobe: assert property (global_clear_out |=> !global_clear_out)
    else $error("clear pulse too long");
  chk_xfer_strobe: assert property (charge_transfer_out |=> !charge_transfer_out)
    else $error("transfer pulse too long");
  chk_clear_run: assert property (global_clear_out
    |-> stat_out.running && !charge_transfer_out) else $error("clear outside run");
  chk_whole_rows: assert property (exp_rows_out != 24'h000000)
    else $error("exposure of zero rows");
  chk_short_class: assert property (stat_out.exposing &&
    (exp_rows_out < cfg_in.region_rows) |-> !stat_out.long_exp) else $error("short marked long");
  chk_long_class: assert property (stat_out.exposing &&
    (exp_rows_out >= cfg_in.region_rows + 4) |-> stat_out.long_exp) else $error("long not marked");
  cover property ($fell(stat_out.trig_ready));
  cover property (global_clear_out && stat_out.long_exp);
  cover property (stat_out.exp_rejected);
endmodule
`default_nettype wire

// ---- sim/gsst_trig_src.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// External trigger source model
module gsst_trig_src (
  input wire logic clk_in,
  input wire logic fire_in,
  input wire logic [3:0] width_in,
  output logic trig_out
);
  logic [3:0] left_reg = 4'h0;
  // Width counts clocks; a width under two shows how a too-short pulse is ignored
  always @(posedge clk_in) begin
    if (fire_in && left_reg == 4'h0) begin
      left_reg <= width_in;
    end else if (left_reg != 4'h0) begin
      left_reg <= left_reg - 4'h1;
    end
  end
  assign trig_out = (left_reg != 4'h0);
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Bench for the start sequencer
module testbench;
  import gsst_pkg::*;
  localparam int RC = 8;
  localparam int FR = 16;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic start = 1'b0;
  logic stop = 1'b0;
  logic fire = 1'b0;
  logic [3:0] width = 4'h0;
  logic trig;
  logic load = 1'b0;
  logic [27:0] frac = 28'h0000010;
  gsst_cfg_t cfg = '{1'b0, 24'h000000, 24'h000000, 12'h010, 12'h002};
  gsst_stat_t stat;
  logic gclr;
  logic xfer;
  logic [23:0] rows;
  int n_mismatch = 0;
  int checks_done = 0;
  int n;
  logic rej;
  logic [23:0] want;
  always #4 clk_in = ~clk_in;
  gsst_trig_src i_src (.clk_in(clk_in), .fire_in(fire), .width_in(width), .trig_out(trig));
  gsst_start_seq #(.ROW_CLKS(RC), .EXP_MAX_ROWS(200)) i_dut (.clk_in(clk_in),
    .arst_n_in(arst_n_in), .acq_start_in(start), .acq_stop_in(stop),
    .external_trigger_input_in(trig), .clk_div_in(8'h00), .cfg_in(cfg),
    .exp_req_frac_in(frac), .exp_req_load_in(load), .stat_out(stat),
    .global_clear_out(gclr), .charge_transfer_out(xfer), .exp_rows_out(rows));
  // ==========================================
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask
  // Bounded wait; a hang counts as a mismatch
  task automatic wait_sig(input int sel, output int c);
    c = 0;
    while (!(sel == 0 ? stat.trig_ready === 1'b1 : sel == 1 ? gclr === 1'b1 :
        sel == 2 ? xfer === 1'b1 : stat.trig_ready === 1'b0) && c < 3000) begin
      tick(1);
      c++;
    end
    check(c < 3000, 1);
  endtask
  task automatic pulse(input logic [3:0] w);
    width = w;
    fire = 1'b1;
    tick(1);
    fire = 1'b0;
  endtask
  task automatic arm;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    wait_sig(0, n);
  endtask
  task automatic req(input logic [27:0] f, output logic r);
    frac = f;
    load = 1'b1;
    tick(1);
    load = 1'b0;
    r = 1'b0;
    repeat (4) begin
      r |= stat.exp_rejected;
      tick(1);
    end
  endtask
  task automatic halt;
    stop = 1'b1;
    tick(1);
    stop = 1'b0;
    tick(2);
  endtask
  function automatic logic [23:0] rounded(input logic [27:0] f);
    return 24'((f + 28'h0000008) >> 4);
  endfunction
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ==========================================
  // Watchdog, far beyond the thousand or so cycles the run needs
  initial begin
    #400000;
    n_mismatch++;
    print_verdict();
  end
  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(32'h79826e48));
    repeat (20) @(posedge clk_in);
    #1;
    check({stat, gclr, xfer, rows}, 32'h00000001);
    arst_n_in = 1'b1;
    tick(1);
    arm();
    check(stat.trig_ready, 1);
    pulse(4'h1);
    tick(6);
    check(stat.trig_ready, 1);
    pulse(4'h2);
    wait_sig(3, n);
    check(n <= 6 && stat.running === 1'b1, 1);
    wait_sig(1, n);
    check(n <= (FR + 2) * RC, 1);
    wait_sig(2, n);
    check(n >= RC - 2 && n <= RC + 2, 1);
    pulse(4'h3);
    tick(4);
    check(stat.trig_ready, 0);
    wait_sig(1, n);
    check(stat.running, 1);
    $display("test start_short done");
    for (int k = 0; k < 2; k++) begin
      frac = {4'h0, 20'($urandom_range(12, 2)), k ? 4'($urandom) : 4'h8};
      want = rounded(frac);
      req(frac, rej);
      check(rej, 0);
      wait_sig(1, n);
      wait_sig(2, n);
      check(rows, want);
      check(stat.reading, 1);
      check(n >= int'(want) * RC - 2 && n <= int'(want) * RC + 2, 1);
    end
    req(28'h0000000, rej);
    check(rej, 1);
    req(28'(FR + 8) << 4, rej);
    check(rej, 1);
    check(rows, want);
    halt();
    check({stat.running, stat.trig_ready}, 0);
    $display("test exposure_change done");
    req(28'(FR + 4) << 4, rej);
    tick(2);
    check(rows, FR + 4);
    arm();
    pulse(4'h2);
    wait_sig(3, n);
    wait_sig(1, n);
    check(n >= RC - 2 && n <= 2 * RC + 2, 1);
    tick(1);
    check(stat.long_exp, 1);
    wait_sig(2, n);
    check(n >= (FR + 4) * RC - 2 && n <= (FR + 4) * RC + 2, 1);
    halt();
    $display("test start_long done");
    print_verdict();
  end
endmodule
bind gsst_start_seq gsst_start_seq_props i_props (.clk_in(clk_in), .arst_n_in(arst_n_in),
  .acq_stop_in(acq_stop_in), .cfg_in(cfg_in), .stat_out(stat_out),
  .global_clear_out(global_clear_out), .charge_transfer_out(charge_transfer_out),
  .exp_rows_out(exp_rows_out));
`default_nettype wire
